// ---- rtl/capture_compare_timer.sv ----
// Added by the designer: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module capture_compare_timer (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // AXI4-Lite write address and data
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read
   input  wire logic [31:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // CPU side
   input  wire logic        cpu_interrupt_mask,
   input  wire logic        halt_mode,
   output logic             timer_irq,
   // Pins
   input  wire logic [1:0]  capture_input_pin,
   input  wire logic        external_count_pin,
   output logic [1:0]       compare_output_pin
);

   // Pin synchronisers: index 0,1 capture pins, 2 external clock
   logic [2:0] pin_in;
   logic [2:0] sync1_r;
   logic [2:0] sync2_r;
   logic [2:0] sync3_r;
   logic [2:0] pin_stable_r;
   logic [2:0] pin_prev_r;
   logic [2:0] pin_rise;
   logic [2:0] pin_fall;

   // Registers and state
   logic [7:0]  ctrl_one_r;
   logic [7:0]  ctrl_two_r;
   logic [15:0] count_r;
   logic [2:0]  prediv_r;
   logic        tick;
   logic        tick_seen_r;
   logic [7:0]  count_buf_r;
   logic        count_seq_r;
   logic [7:0]  shadow_buf_r;
   logic        shadow_seq_r;
   logic [15:0] capture_r [2];
   logic [1:0]  capture_lock_r;
   logic [15:0] compare_r [2];
   logic [1:0]  compare_hold_r;
   logic [1:0]  pin_level_r;
   logic [timer_pkg::NUM_FLAGS-1:0] flag_r;
   logic [timer_pkg::NUM_FLAGS-1:0] arm_r;
   logic [timer_pkg::NUM_FLAGS-1:0] flag_set;
   logic [timer_pkg::NUM_FLAGS-1:0] flag_access;
   logic [1:0]  cap_event;
   logic [1:0]  cap_edge_sel;
   logic [1:0]  cmp_match;

   // Bus state
   logic        aw_held_r;
   logic        w_held_r;
   logic [5:0]  waddr_r;
   logic [7:0]  wbyte_r;
   logic        wlane_r;
   logic        wr_do;
   logic        rd_do;
   logic [5:0]  raddr;
   logic [7:0]  rd_byte;
   logic        rd_hit;
   logic        wr_hit;

   assign pin_in = {external_count_pin, capture_input_pin};

   // Three stages; a change counts only once stages two and three agree
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_sync
         always_ff @(posedge clk) begin
            if (sys_rst) begin
               sync1_r[g]      <= 1'b0;
               sync2_r[g]      <= 1'b0;
               sync3_r[g]      <= 1'b0;
               pin_stable_r[g] <= 1'b0;
               pin_prev_r[g]   <= 1'b0;
            end else begin
               sync1_r[g] <= pin_in[g];
               sync2_r[g] <= sync1_r[g];
               sync3_r[g] <= sync2_r[g];
               if (sync2_r[g] == sync3_r[g]) begin
                  pin_stable_r[g] <= sync3_r[g];
               end
               pin_prev_r[g] <= pin_stable_r[g];
            end
         end
         assign pin_rise[g] = pin_stable_r[g] & ~pin_prev_r[g];
         assign pin_fall[g] = ~pin_stable_r[g] & pin_prev_r[g];
      end
   endgenerate

   // Bus handshakes: address and data taken in either order
   assign s_axi_awready = ~aw_held_r & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_held_r & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;
   assign wr_do = aw_held_r & w_held_r & ~s_axi_bvalid;
   assign rd_do = s_axi_arvalid & s_axi_arready;
   assign raddr = s_axi_araddr[5:0];

   // Write channel capture and response
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         aw_held_r    <= 1'b0;
         w_held_r     <= 1'b0;
         waddr_r      <= 6'h00;
         wbyte_r      <= 8'h00;
         wlane_r      <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= timer_pkg::RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            waddr_r   <= (s_axi_awaddr[31:6] == 26'h0) ? s_axi_awaddr[5:0] : 6'h3f;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            wbyte_r  <= s_axi_wdata[7:0];
            wlane_r  <= s_axi_wstrb[0];
         end
         if (wr_do) begin
            aw_held_r    <= 1'b0;
            w_held_r     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? timer_pkg::RESP_OKAY : timer_pkg::RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Write address decode
   always_comb begin
      case (waddr_r)
         timer_pkg::ADDR_CTRL_ONE, timer_pkg::ADDR_CTRL_TWO, timer_pkg::ADDR_STATUS,
         timer_pkg::ADDR_CAP1_HIGH, timer_pkg::ADDR_CAP1_LOW, timer_pkg::ADDR_CMP1_HIGH,
         timer_pkg::ADDR_CMP1_LOW, timer_pkg::ADDR_CAP2_HIGH, timer_pkg::ADDR_CAP2_LOW,
         timer_pkg::ADDR_CMP2_HIGH, timer_pkg::ADDR_CMP2_LOW, timer_pkg::ADDR_COUNT_HIGH,
         timer_pkg::ADDR_COUNT_LOW, timer_pkg::ADDR_SHADOW_HIGH,
         timer_pkg::ADDR_SHADOW_LOW: wr_hit = 1'b1;
         default:                    wr_hit = 1'b0;
      endcase
   end

   // Read data mux; low reads of a count view give the buffer inside a sequence
   always_comb begin
      rd_hit  = 1'b1;
      rd_byte = 8'h00;
      case (raddr)
         timer_pkg::ADDR_CTRL_ONE:    rd_byte = ctrl_one_r;
         timer_pkg::ADDR_CTRL_TWO:    rd_byte = ctrl_two_r;
         timer_pkg::ADDR_STATUS:      rd_byte = {3'h0, flag_r};
         timer_pkg::ADDR_CAP1_HIGH:   rd_byte = capture_r[0][15:8];
         timer_pkg::ADDR_CAP1_LOW:    rd_byte = capture_r[0][7:0];
         timer_pkg::ADDR_CMP1_HIGH:   rd_byte = compare_r[0][15:8];
         timer_pkg::ADDR_CMP1_LOW:    rd_byte = compare_r[0][7:0];
         timer_pkg::ADDR_CAP2_HIGH:   rd_byte = capture_r[1][15:8];
         timer_pkg::ADDR_CAP2_LOW:    rd_byte = capture_r[1][7:0];
         timer_pkg::ADDR_CMP2_HIGH:   rd_byte = compare_r[1][15:8];
         timer_pkg::ADDR_CMP2_LOW:    rd_byte = compare_r[1][7:0];
         timer_pkg::ADDR_COUNT_HIGH,
         timer_pkg::ADDR_SHADOW_HIGH: rd_byte = count_r[15:8];
         timer_pkg::ADDR_COUNT_LOW:   rd_byte = count_seq_r ? count_buf_r : count_r[7:0]; // RULE_06
         timer_pkg::ADDR_SHADOW_LOW:  rd_byte = shadow_seq_r ? shadow_buf_r : count_r[7:0]; // RULE_02
         default:                     rd_hit = 1'b0;
      endcase
      if (s_axi_araddr[31:6] != 26'h0) begin
         rd_hit  = 1'b0;
         rd_byte = 8'h00;
      end
   end

   // Read response; unmapped addresses read zero with an error
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= timer_pkg::RESP_OKAY;
      end else if (rd_do) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= {24'h00_0000, rd_byte};
         s_axi_rresp  <= rd_hit ? timer_pkg::RESP_OKAY : timer_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Control registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctrl_one_r <= timer_pkg::CTRL_RESET;
         ctrl_two_r <= timer_pkg::CTRL_RESET;
      end else if (wr_do && wlane_r) begin
         if (waddr_r == timer_pkg::ADDR_CTRL_ONE) begin
            ctrl_one_r <= wbyte_r;
         end
         if (waddr_r == timer_pkg::ADDR_CTRL_TWO) begin
            ctrl_two_r <= wbyte_r;
         end
      end
   end

   // Timer tick: free divider or synchronised external edge; halt stops it
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         prediv_r <= 3'h0;
      end else begin
         prediv_r <= prediv_r + 3'h1;
      end
   end

   always_comb begin
      case (ctrl_two_r[timer_pkg::CR2_CLK_SEL_HI:timer_pkg::CR2_CLK_SEL_LO]) // RULE_05
         timer_pkg::CLK_DIV2: tick = prediv_r[0];
         timer_pkg::CLK_DIV4: tick = &prediv_r[1:0];
         timer_pkg::CLK_DIV8: tick = &prediv_r;
         timer_pkg::CLK_EXT:  tick = ctrl_two_r[timer_pkg::CR2_EXT_EDGE] ? pin_rise[2]
                                                                         : pin_fall[2]; // RULE_11
         default:             tick = 1'b0;
      endcase
      if (halt_mode) begin
         tick = 1'b0; // RULE_10
      end
   end

   // Free-running counter; a low-byte write of either view wins over a tick
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         count_r     <= timer_pkg::COUNT_RESET; // RULE_04
         tick_seen_r <= 1'b0;
      end else begin
         tick_seen_r <= tick;
         if (wr_do && (waddr_r == timer_pkg::ADDR_COUNT_LOW ||
                       waddr_r == timer_pkg::ADDR_SHADOW_LOW)) begin
            count_r <= timer_pkg::COUNT_RESET; // RULE_03
         end else if (tick) begin
            count_r <= count_r + 16'h0001; // RULE_01 RULE_25
         end
      end
   end

   // Read buffers; repeated high reads keep the first latched low byte
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         count_seq_r  <= 1'b0;
         count_buf_r  <= 8'h00;
         shadow_seq_r <= 1'b0;
         shadow_buf_r <= 8'h00;
      end else if (rd_do) begin
         if (raddr == timer_pkg::ADDR_COUNT_HIGH && !count_seq_r) begin
            count_seq_r <= 1'b1; // RULE_06
            count_buf_r <= count_r[7:0];
         end
         if (raddr == timer_pkg::ADDR_COUNT_LOW) begin
            count_seq_r <= 1'b0;
         end
         if (raddr == timer_pkg::ADDR_SHADOW_HIGH && !shadow_seq_r) begin
            shadow_seq_r <= 1'b1;
            shadow_buf_r <= count_r[7:0];
         end
         if (raddr == timer_pkg::ADDR_SHADOW_LOW) begin
            shadow_seq_r <= 1'b0;
         end
      end
   end

   // Edge selects sit in different control registers
   assign cap_edge_sel[0] = ctrl_one_r[timer_pkg::CR1_CAP_EDGE1]; // RULE_14
   assign cap_edge_sel[1] = ctrl_two_r[timer_pkg::CR2_CAP_EDGE2];

   // Capture channels; pins are watched regardless of their direction
   generate
      for (g = 0; g < 2; g++) begin : g_cap
         logic cap_high_rd;
         logic cap_low_rd;
         logic chan_on;
         assign cap_high_rd = rd_do && raddr == (g == 0 ? timer_pkg::ADDR_CAP1_HIGH
                                                        : timer_pkg::ADDR_CAP2_HIGH);
         assign cap_low_rd  = rd_do && raddr == (g == 0 ? timer_pkg::ADDR_CAP1_LOW
                                                        : timer_pkg::ADDR_CAP2_LOW);
         // Channel one is taken over by the pulse modes
         assign chan_on = (g == 1) || !(ctrl_two_r[timer_pkg::CR2_ONE_PULSE] |
                                        ctrl_two_r[timer_pkg::CR2_PWM]); // RULE_19
         assign cap_event[g] = chan_on && !capture_lock_r[g] &&
                               (cap_edge_sel[g] ? pin_rise[g] : pin_fall[g]); // RULE_13 RULE_20
         always_ff @(posedge clk) begin
            if (sys_rst) begin
               capture_r[g]      <= 16'h0000;
               capture_lock_r[g] <= 1'b0;
            end else begin
               if (cap_event[g]) begin
                  capture_r[g] <= count_r; // RULE_18
               end
               if (cap_high_rd) begin
                  capture_lock_r[g] <= 1'b1; // RULE_17
               end else if (cap_low_rd) begin
                  capture_lock_r[g] <= 1'b0;
               end
            end
         end
      end
   endgenerate

   // Compare channels: write high suspends, write low resumes
   generate
      for (g = 0; g < 2; g++) begin : g_cmp
         logic [5:0] hi_addr;
         logic [5:0] lo_addr;
         logic       out_en;
         logic       level;
         assign hi_addr = g == 0 ? timer_pkg::ADDR_CMP1_HIGH : timer_pkg::ADDR_CMP2_HIGH;
         assign lo_addr = g == 0 ? timer_pkg::ADDR_CMP1_LOW : timer_pkg::ADDR_CMP2_LOW;
         assign out_en  = ctrl_two_r[g == 0 ? timer_pkg::CR2_OUT_EN1 : timer_pkg::CR2_OUT_EN2];
         assign level   = ctrl_one_r[g == 0 ? timer_pkg::CR1_LEVEL_ONE : timer_pkg::CR1_LEVEL_TWO];
         // Checked the cycle after each tick, against the new count
         assign cmp_match[g] = tick_seen_r && !compare_hold_r[g] &&
                               count_r == compare_r[g]; // RULE_21
         always_ff @(posedge clk) begin
            if (sys_rst) begin
               compare_r[g]      <= timer_pkg::COMPARE_RESET; // RULE_22
               compare_hold_r[g] <= 1'b0;
               pin_level_r[g]    <= 1'b0;
            end else begin
               if (wr_do && wlane_r && waddr_r == hi_addr) begin
                  compare_r[g][15:8] <= wbyte_r;
                  compare_hold_r[g]  <= 1'b1; // RULE_24
               end
               if (wr_do && wlane_r && waddr_r == lo_addr) begin
                  compare_r[g][7:0] <= wbyte_r;
                  compare_hold_r[g] <= 1'b0;
               end
               // Pin only follows a match while its output is enabled
               if (cmp_match[g] && out_en) begin
                  pin_level_r[g] <= level; // RULE_21
               end
            end
         end
      end
   endgenerate

   assign compare_output_pin = pin_level_r;

   // Flag sources
   assign flag_set[timer_pkg::FLAG_OVF]  = tick && count_r == timer_pkg::COUNT_MAX; // RULE_07
   assign flag_set[timer_pkg::FLAG_CAP1] = cap_event[0]; // RULE_15
   assign flag_set[timer_pkg::FLAG_CAP2] = cap_event[1];
   assign flag_set[timer_pkg::FLAG_CMP1] = cmp_match[0];
   assign flag_set[timer_pkg::FLAG_CMP2] = cmp_match[1];

   // Second-step accesses; the shadow low byte is deliberately absent
   assign flag_access[timer_pkg::FLAG_OVF] =
      (rd_do && raddr == timer_pkg::ADDR_COUNT_LOW) ||
      (wr_do && waddr_r == timer_pkg::ADDR_COUNT_LOW); // RULE_09
   assign flag_access[timer_pkg::FLAG_CAP1] =
      (rd_do && raddr == timer_pkg::ADDR_CAP1_LOW) ||
      (wr_do && waddr_r == timer_pkg::ADDR_CAP1_LOW); // RULE_16
   assign flag_access[timer_pkg::FLAG_CAP2] =
      (rd_do && raddr == timer_pkg::ADDR_CAP2_LOW) ||
      (wr_do && waddr_r == timer_pkg::ADDR_CAP2_LOW);
   assign flag_access[timer_pkg::FLAG_CMP1] =
      (rd_do && raddr == timer_pkg::ADDR_CMP1_LOW) ||
      (wr_do && waddr_r == timer_pkg::ADDR_CMP1_LOW); // RULE_23
   assign flag_access[timer_pkg::FLAG_CMP2] =
      (rd_do && raddr == timer_pkg::ADDR_CMP2_LOW) ||
      (wr_do && waddr_r == timer_pkg::ADDR_CMP2_LOW);

   // Two-step clear: status read arms seen flags, access clears; a new set wins
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         flag_r <= '0;
         arm_r  <= '0;
      end else begin
         flag_r <= (flag_r & ~(arm_r & flag_access)) | flag_set; // RULE_09 RULE_16 RULE_23
         if (rd_do && raddr == timer_pkg::ADDR_STATUS) begin
            arm_r <= flag_r;
         end else begin
            arm_r <= arm_r & ~flag_access;
         end
      end
   end

   // Interrupt request held while pending and unmasked
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         timer_irq <= 1'b0;
      end else begin
         timer_irq <= !cpu_interrupt_mask &&
            ((ctrl_one_r[timer_pkg::CR1_OVF_IE] && flag_r[timer_pkg::FLAG_OVF]) || // RULE_08
             (ctrl_one_r[timer_pkg::CR1_CAP_IE] &&
              (flag_r[timer_pkg::FLAG_CAP1] || flag_r[timer_pkg::FLAG_CAP2])) || // RULE_15
             (ctrl_one_r[timer_pkg::CR1_CMP_IE] &&
              (flag_r[timer_pkg::FLAG_CMP1] || flag_r[timer_pkg::FLAG_CMP2])));
      end
   end

endmodule

// ---- shared/timer_pkg.sv ----
// Notes on behaviour
// RULE_01: A 16-bit up-counter, read by software as a high byte and a low byte.
// RULE_02: A read-only shadow count view; reading its low byte never clears overflow flag. Here a shadow low-byte write reloads the counter.
// RULE_03: Writing either count low byte reloads the counter with FFFCh.
// RULE_04: FFFCh is the counter reset value in every mode and the only reload value.
// RULE_05: Counter ticks at CPU clock divided by 2, 4, 8, or from external pin.
// RULE_06: High byte read latches low byte; buffer holds until low read, else live.
// RULE_07: Rolling over from FFFFh to 0000h sets the overflow flag in every mode.
// RULE_08: Overflow interrupt requested only with its enable set and CPU mask clear; else pending.
// RULE_09: Overflow flag clears after status read seeing it, then count low access.
// RULE_10: Wait leaves counting alone; halt freezes the count, resuming from held count.
// RULE_11: Clock select 11 picks external pin; polarity bit picks its active edge.
// RULE_12: External clock keeps four CPU edges between active edges; below quarter rate.
// RULE_13: Each 16-bit capture register latches the count on its pin's active edge.
// RULE_14: Edge select per channel in control two/one; one capture enable covers both. Here channel one's select is in control one, channel two's in control two.
// RULE_15: Capture sets the channel flag; interrupt with enable and clear mask, else pending.
// RULE_16: Capture flag clears after status read seeing it, then capture low access.
// RULE_17: After capture high read, captures and flag are blocked until low read.
// RULE_18: Each capture register holds the most recent capture, overwriting older values.
// RULE_19: In one pulse or PWM mode only capture channel two operates.
// RULE_20: Capture pins feed the timer whatever their direction; toggling still captures.
// RULE_21: Each timer tick compare registers meet counter; match drives pin, flag, interrupt.
// RULE_22: Compare registers are read/write, untouched by hardware, reset to 8000h.
// RULE_23: Compare flag clears after status read seeing it, then compare low access.
// RULE_24: Writing compare high suspends that channel's compare until its low is written.
// RULE_25: After FFFFh the counter continues from zero, not from the reset value.
package timer_pkg;

   // Register byte addresses, one aligned word each
   localparam logic [5:0] ADDR_CTRL_ONE     = 6'h00;
   localparam logic [5:0] ADDR_CTRL_TWO     = 6'h04;
   localparam logic [5:0] ADDR_STATUS       = 6'h08;
   localparam logic [5:0] ADDR_CAP1_HIGH    = 6'h0c;
   localparam logic [5:0] ADDR_CAP1_LOW     = 6'h10;
   localparam logic [5:0] ADDR_CMP1_HIGH    = 6'h14;
   localparam logic [5:0] ADDR_CMP1_LOW     = 6'h18;
   localparam logic [5:0] ADDR_CAP2_HIGH    = 6'h1c;
   localparam logic [5:0] ADDR_CAP2_LOW     = 6'h20;
   localparam logic [5:0] ADDR_CMP2_HIGH    = 6'h24;
   localparam logic [5:0] ADDR_CMP2_LOW     = 6'h28;
   localparam logic [5:0] ADDR_COUNT_HIGH   = 6'h2c;
   localparam logic [5:0] ADDR_COUNT_LOW    = 6'h30;
   localparam logic [5:0] ADDR_SHADOW_HIGH  = 6'h34;
   localparam logic [5:0] ADDR_SHADOW_LOW   = 6'h38;

   // Control register one fields
   localparam int CR1_CAP_IE      = 7;
   localparam int CR1_CMP_IE      = 6;
   localparam int CR1_OVF_IE      = 5;
   localparam int CR1_LEVEL_TWO   = 2;
   localparam int CR1_CAP_EDGE1   = 1;
   localparam int CR1_LEVEL_ONE   = 0;

   // Control register two fields
   localparam int CR2_OUT_EN1     = 7;
   localparam int CR2_OUT_EN2     = 6;
   localparam int CR2_ONE_PULSE   = 5;
   localparam int CR2_PWM         = 4;
   localparam int CR2_CLK_SEL_HI  = 3;
   localparam int CR2_CLK_SEL_LO  = 2;
   localparam int CR2_CAP_EDGE2   = 1;
   localparam int CR2_EXT_EDGE    = 0;

   // Flag vector positions, also the status byte layout
   localparam int FLAG_OVF        = 0;
   localparam int FLAG_CAP1       = 1;
   localparam int FLAG_CAP2       = 2;
   localparam int FLAG_CMP1       = 3;
   localparam int FLAG_CMP2       = 4;
   localparam int NUM_FLAGS       = 5;

   // Clock select encodings
   localparam logic [1:0] CLK_DIV4 = 2'h0;
   localparam logic [1:0] CLK_DIV2 = 2'h1;
   localparam logic [1:0] CLK_DIV8 = 2'h2;
   localparam logic [1:0] CLK_EXT  = 2'h3;

   // Reset values and the count maximum
   localparam logic [15:0] COUNT_RESET   = 16'hfffc;
   localparam logic [15:0] COUNT_MAX     = 16'hffff;
   localparam logic [15:0] COMPARE_RESET = 16'h8000;
   localparam logic [7:0]  CTRL_RESET    = 8'h00;

   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ---- verification/capture_compare_timer_tb.sv ----
`timescale 1ns/1ns
module capture_compare_timer_tb;
   logic        clk, sys_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic        s_axi_rready, cpu_interrupt_mask, halt_mode, timer_irq, external_count_pin;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rdv;
   logic [1:0]  s_axi_bresp, s_axi_rresp, capture_input_pin, compare_output_pin, rsp;
   logic [3:0]  s_axi_wstrb;
   logic [7:0]  hi_v, lo_v;
   logic        ta, tw, tr, done;
   int          mismatches, n_tests;

   capture_compare_timer uut (.*);
   pin_partner pp (.clk(clk), .capture_input_pin(capture_input_pin),
                   .external_count_pin(external_count_pin));

   // 25 MHz clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Handshakes read at the falling edge; inputs move at rising edges
   task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] d);
      int n;
      @(posedge clk);
      if (w) begin
         s_axi_awaddr <= {26'h0, a};
         s_axi_wdata <= {24'h0, d};
         {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      end else begin
         s_axi_araddr <= {26'h0, a};
         {s_axi_arvalid, s_axi_rready} <= 2'h3;
      end
      done = 1'b0;
      for (n = 0; n < 40 && !done; n++) begin
         @(negedge clk);
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         tr = s_axi_arvalid && s_axi_arready;
         done = w ? s_axi_bvalid : s_axi_rvalid;
         rdv = s_axi_rdata;
         rsp = w ? s_axi_bresp : s_axi_rresp;
         @(posedge clk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
         if (tr) s_axi_arvalid <= 1'b0;
      end
      {s_axi_bready, s_axi_rready} <= 2'h0;
      chk("bus answer", done, 1'b1);
   endtask

   task automatic rd(input logic [5:0] a, input logic [7:0] e, input string nm);
      acc(1'b0, a, 8'h00);
      chk(nm, rdv, {24'h0, e});
   endtask

   task end_sim;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Hang guard, far beyond the sequence length
   initial begin
      repeat (6000) @(posedge clk);
      mismatches++;
      end_sim;
   end

   // Main sequence
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
      s_axi_wstrb = 4'h1;
      {sys_rst, cpu_interrupt_mask, halt_mode} = 3'h6;
      {mismatches, n_tests} = 64'h0;
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
      rd(6'h2c, 8'hff, "count high");
      rd(6'h30, 8'hfc, "count low");
      rd(6'h14, 8'h80, "compare high");
      rd(6'h18, 8'h00, "compare low");
      rd(6'h3c, 8'h00, "unmapped");
      chk("unmapped resp", rsp, 2'h2);
      // External counting through the wrap
      acc(1'b1, 6'h00, 8'h20);
      acc(1'b1, 6'h04, 8'h0d);
      acc(1'b1, 6'h30, 8'h00);
      pp.ext_pulses(6);
      repeat (8) @(posedge clk);
      rd(6'h08, 8'h01, "status");
      chk("irq masked", timer_irq, 1'b0);
      cpu_interrupt_mask <= 1'b0;
      repeat (3) @(posedge clk);
      chk("irq", timer_irq, 1'b1);
      rd(6'h38, 8'h02, "shadow low");
      rd(6'h08, 8'h01, "status kept");
      rd(6'h2c, 8'h00, "count high");
      rd(6'h30, 8'h02, "count low");
      rd(6'h08, 8'h00, "status clear");
      chk("irq gone", timer_irq, 1'b0);
      cpu_interrupt_mask <= 1'b1;
      // Buffered low byte and halt freeze
      acc(1'b1, 6'h04, 8'h04);
      halt_mode <= 1'b1;
      acc(1'b1, 6'h30, 8'h00);
      rd(6'h2c, 8'hff, "count high");
      halt_mode <= 1'b0;
      repeat (30) @(posedge clk);
      halt_mode <= 1'b1;
      rd(6'h30, 8'hfc, "buffered low");
      acc(1'b0, 6'h2c, 8'h00);
      hi_v = rdv[7:0];
      acc(1'b0, 6'h30, 8'h00);
      lo_v = rdv[7:0];
      chk("wrapped high", hi_v, 8'h00);
      repeat (20) @(posedge clk);
      rd(6'h2c, hi_v, "halt high");
      rd(6'h30, lo_v, "halt low");
      // Capture of the frozen count
      acc(1'b1, 6'h00, 8'h02);
      pp.cap_pulse(0);
      acc(1'b0, 6'h08, 8'h00);
      chk("capture flag", rdv[1], 1'b1);
      rd(6'h0c, hi_v, "capture high");
      rd(6'h10, lo_v, "capture low");
      acc(1'b0, 6'h08, 8'h00);
      chk("capture clear", rdv[1], 1'b0);
      // Compare match drives the pin
      halt_mode <= 1'b0;
      acc(1'b1, 6'h00, 8'h01);
      acc(1'b1, 6'h04, 8'h84);
      acc(1'b1, 6'h14, 8'h00);
      acc(1'b1, 6'h18, 8'h20);
      acc(1'b1, 6'h30, 8'h00);
      repeat (100) @(posedge clk);
      chk("compare pin", compare_output_pin[0], 1'b1);
      acc(1'b0, 6'h08, 8'h00);
      chk("compare flag", rdv[3], 1'b1);
      end_sim;
   end
endmodule

// ---- verification/pin_partner.sv ----
`timescale 1ns/1ns
// Far side: capture and counting clock pins
module pin_partner (
   // Clock
   input wire logic clk,
   // Pins toward the timer
   output logic [1:0] capture_input_pin,
   output logic       external_count_pin
);
   // Pins idle low
   initial begin
      capture_input_pin = 2'h0;
      external_count_pin = 1'b0;
   end

   // Edges six or seven cycles apart, rising edges thirteen apart, well past the input filters
   task automatic ext_pulses(input int n);
      repeat (n) begin
         @(posedge clk) external_count_pin <= 1'b1;
         repeat (6) @(posedge clk);
         external_count_pin <= 1'b0;
         repeat (6) @(posedge clk);
      end
   endtask

   // Pulse on a capture pin whatever its direction
   task automatic cap_pulse(input int ch);
      @(posedge clk) capture_input_pin[ch] <= 1'b1;
      repeat (8) @(posedge clk);
      capture_input_pin[ch] <= 1'b0;
      repeat (8) @(posedge clk);
   endtask
endmodule

// ---- verification/timer_chk.sv ----
`timescale 1ns/1ns
// Port relations, bound at the timer's top
module timer_chk (
   // Clock and reset
   input wire logic       clk,
   input wire logic       sys_rst,
   // Register bus
   input wire logic       s_axi_awvalid,
   input wire logic       s_axi_awready,
   input wire logic       s_axi_wvalid,
   input wire logic       s_axi_wready,
   input wire logic       s_axi_bvalid,
   input wire logic       s_axi_bready,
   input wire logic       s_axi_arvalid,
   input wire logic       s_axi_arready,
   input wire logic       s_axi_rvalid,
   input wire logic       s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   // CPU side and pins
   input wire logic       cpu_interrupt_mask,
   input wire logic       halt_mode,
   input wire logic       timer_irq,
   input wire logic [1:0] compare_output_pin
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);

   bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped early");
   rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata)) else $error("read data not held");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
   write_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   read_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while data pending");
   masked_irq_a: assert property (cpu_interrupt_mask |=> !timer_irq)
      else $error("interrupt while masked");
   halt_pins_a: assert property (halt_mode [*4] |-> $stable(compare_output_pin))
      else $error("compare pin moved in halt");
endmodule

bind capture_compare_timer timer_chk chk_i (.*);
